// ===== logic/mtl_pkg.sv
// package for the master tenure latency timer block
// shared by the sequencer, its tenure counter and its data-phase watchdog; one bus clock
package mtl_pkg;

	// counter widths
	localparam int CNT_W = 8;
	localparam int REM_W = 9;

	// bus command that gets cacheline-aware termination
	localparam logic [3:0] CMD_MWI = 4'hf;

	// data-phase limits in bus clocks
	localparam logic [5:0] MASTER_RDY_LIMIT = 6'h08;
	localparam logic [5:0] TGT_INIT_LIMIT = 6'h10;
	localparam logic [5:0] TGT_INIT_HBB_LIMIT = 6'h20;
	localparam logic [5:0] TGT_SUBSEQ_LIMIT = 6'h08;

	// termination after expiry for ordinary commands: current phase and one more
	localparam logic [REM_W-1:0] NON_MWI_CUT = 9'h002;

	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [REM_W-1:0] REM_RST = 9'h000;
	localparam logic [5:0] PHASE_CNT_RST = 6'h00;
	localparam logic [3:0] CMD_RST = 4'h0;

	// one transfer request from the user side
	typedef struct packed
	{
		logic [3:0] cmd;
		logic [CNT_W-1:0] len;
		logic [CNT_W-1:0] line_ofs;
	} mtl_req_s;

	// status pulses and levels toward the user side
	typedef struct packed
	{
		logic lt_expired;
		logic cut_active;
		logic irdy_forced;
		logic tgt_late;
		logic phase_done;
	} mtl_stat_s;

	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_ARB = 5'h02,
		ST_ADDR = 5'h04,
		ST_DATA = 5'h08,
		ST_TURN = 5'h10
	} mtl_state_e;

endpackage

// ===== logic/mtl_tenure_ctr.sv
// tenure counter: counts bus clocks while the master holds its frame
// assumes frame_act is the master's own registered frame drive
`timescale 1ns/10ps
module mtl_tenure_ctr
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_act,
	input wire logic [mtl_pkg::CNT_W-1:0] lt_value,
	output logic expired
);

	logic [mtl_pkg::CNT_W-1:0] cnt_r;
	logic [mtl_pkg::CNT_W-1:0] cnt_nxt;
	logic exp_r;
	logic exp_nxt;
	wire logic at_limit = (cnt_r == lt_value);
	wire logic cnt_full = (cnt_r == {mtl_pkg::CNT_W{1'b1}});

	// cleared and held while frame is not driven, counting from frame assertion
	assign cnt_nxt = !frame_act ? mtl_pkg::CNT_RST : (cnt_full ? cnt_r : cnt_r + 8'h01);
	// flag stays set until frame is released
	assign exp_nxt = frame_act & (exp_r | at_limit);
	assign expired = frame_act & (exp_r | at_limit);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r <= mtl_pkg::CNT_RST;
			exp_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

endmodule // mtl_tenure_ctr

// ===== logic/mtl_phase_wdog.sv
// data-phase watchdog: clocks spent in the current data phase
// assumes active covers the address clock and every data phase of the master's tenure
`timescale 1ns/10ps
module mtl_phase_wdog
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic active,
	input wire logic phase_done,
	input wire logic first_phase,
	input wire logic tgt_resp,
	input wire logic hbb_mode,
	output logic irdy_due,
	output logic tgt_late
);

	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic late_r;
	wire logic cnt_full = (cnt_r == 6'h3f);
	wire logic [5:0] init_lim = hbb_mode ? mtl_pkg::TGT_INIT_HBB_LIMIT : mtl_pkg::TGT_INIT_LIMIT;
	wire logic [5:0] tgt_lim = first_phase ? init_lim : mtl_pkg::TGT_SUBSEQ_LIMIT;

	assign cnt_nxt = (!active || phase_done) ? mtl_pkg::PHASE_CNT_RST : (cnt_full ? cnt_r : cnt_r + 6'h01);
	// eighth clock of a phase counts 7 from its first clock
	assign irdy_due = active & (cnt_r >= mtl_pkg::MASTER_RDY_LIMIT - 6'h01);
	// one pulse per phase when the target overran its response limit
	assign tgt_late = active & !tgt_resp & !late_r & (cnt_r >= tgt_lim);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r <= mtl_pkg::PHASE_CNT_RST;
			late_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			late_r <= (active & !phase_done) & (late_r | tgt_late);
		end
	end

endmodule // mtl_phase_wdog

// ===== logic/mtl_master_tenure.sv
// bus master sequencer with tenure latency timer
// drives frame, irdy and request; samples grant, target ready, stop and bus pins on CLK
// frame and irdy are open for sharing: each has input, output and output enable
`timescale 1ns/10ps

module mtl_master_tenure
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire mtl_pkg::mtl_req_s REQ,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic USER_RDY,
	input wire logic [mtl_pkg::CNT_W-1:0] LAT_TIMER,
	input wire logic [mtl_pkg::CNT_W-1:0] LINE_DWORDS,
	input wire logic HBB_MODE,
	output logic REQ_N,
	input wire logic GNT_N,
	input wire logic FRAME_N_I,
	output logic FRAME_N_O,
	output logic FRAME_N_OE,
	input wire logic IRDY_N_I,
	output logic IRDY_N_O,
	output logic IRDY_N_OE,
	input wire logic TRDY_N,
	input wire logic STOP_N,
	output logic [3:0] BUS_CMD,
	output logic BUSY,
	output mtl_pkg::mtl_stat_s STAT
);

	mtl_pkg::mtl_state_e state_r;
	mtl_pkg::mtl_state_e state_nxt;
	logic frame_n_r;
	logic frame_n_nxt;
	logic [mtl_pkg::REM_W-1:0] rem_r;
	logic [mtl_pkg::REM_W-1:0] rem_nxt;
	logic [mtl_pkg::CNT_W-1:0] pos_r;
	logic [mtl_pkg::CNT_W-1:0] pos_nxt;
	logic cut_r;
	logic first_r;
	logic [3:0] cmd_r;
	logic oe_r;
	logic lt_expired;
	logic irdy_due;
	logic tgt_late;

	// state decode
	wire logic in_idle = (state_r == mtl_pkg::ST_IDLE);
	wire logic in_arb = (state_r == mtl_pkg::ST_ARB);
	wire logic in_addr = (state_r == mtl_pkg::ST_ADDR);
	wire logic in_data = (state_r == mtl_pkg::ST_DATA);
	wire logic frame_act = !frame_n_r && (in_addr || in_data);

	// bus idle when neither frame nor irdy is asserted by anyone
	wire logic bus_idle = FRAME_N_I & IRDY_N_I;
	wire logic granted = !GNT_N;
	wire logic start_ok = in_arb & granted & bus_idle;

	// irdy forced by the eighth clock even if user data is late
	wire logic irdy_act = in_data & (USER_RDY | irdy_due);
	wire logic tgt_resp = !TRDY_N | !STOP_N;
	wire logic phase_done = irdy_act & tgt_resp;
	wire logic stop_seen = in_data & !STOP_N;
	wire logic last_phase_done = phase_done & frame_n_r;

	// cacheline position
	wire logic line_valid = (LINE_DWORDS != 8'h00);
	wire logic [mtl_pkg::CNT_W-1:0] line_last = LINE_DWORDS - 8'h01;
	wire logic at_line_last = line_valid & (pos_r == line_last);
	wire logic is_mwi = (cmd_r == mtl_pkg::CMD_MWI) & line_valid;

	// phases still owed once the timer has expired and grant is gone
	wire logic [mtl_pkg::REM_W-1:0] to_line_end = {1'b0, LINE_DWORDS - pos_r};
	wire logic [mtl_pkg::REM_W-1:0] next_line_end = {1'b0, LINE_DWORDS} + 9'h001;
	wire logic [mtl_pkg::REM_W-1:0] cut_val = !is_mwi ? mtl_pkg::NON_MWI_CUT :
		(at_line_last ? next_line_end : to_line_end);

	// cut once, only with frame still driven and grant removed
	wire logic cut_now = in_data & frame_act & lt_expired & GNT_N & !cut_r;
	wire logic [mtl_pkg::REM_W-1:0] eff_rem = (cut_now && (cut_val < rem_r)) ? cut_val : rem_r;
	wire logic [mtl_pkg::REM_W-1:0] rem_after = phase_done ? eff_rem - 9'h001 : eff_rem;
	wire logic [mtl_pkg::REM_W-1:0] req_len = (REQ.len == 8'h00) ? 9'h001 : {1'b0, REQ.len};

	mtl_tenure_ctr u_tenure_ctr
	(
		.clk(CLK),
		.rst_n(RST_N),
		.frame_act(frame_act),
		.lt_value(LAT_TIMER),
		.expired(lt_expired)
	);

	mtl_phase_wdog u_phase_wdog
	(
		.clk(CLK),
		.rst_n(RST_N),
		.active(in_addr | in_data),
		.phase_done(phase_done),
		.first_phase(first_r),
		.tgt_resp(in_data & tgt_resp),
		.hbb_mode(HBB_MODE),
		.irdy_due(irdy_due),
		.tgt_late(tgt_late)
	);

	// next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			mtl_pkg::ST_IDLE:
			begin
				if (REQ_VALID)
					state_nxt = mtl_pkg::ST_ARB;
			end
			mtl_pkg::ST_ARB:
			begin
				if (start_ok)
					state_nxt = mtl_pkg::ST_ADDR;
			end
			mtl_pkg::ST_ADDR:
				state_nxt = mtl_pkg::ST_DATA;
			mtl_pkg::ST_DATA:
			begin
				if (last_phase_done)
					state_nxt = mtl_pkg::ST_TURN;
			end
			mtl_pkg::ST_TURN:
				state_nxt = mtl_pkg::ST_IDLE;
			default:
				state_nxt = mtl_pkg::ST_IDLE;
		endcase
	end

	// frame: released when the final phase begins or when the target stops
	always_comb
	begin
		frame_n_nxt = frame_n_r;
		if (start_ok)
			frame_n_nxt = 1'b0;
		else if (in_addr)
			frame_n_nxt = (rem_r <= 9'h001);
		else if (in_data && stop_seen)
			frame_n_nxt = 1'b1;
		else if (in_data)
			frame_n_nxt = frame_n_r | (rem_after <= 9'h001);
		else
			frame_n_nxt = 1'b1;
	end

	// remaining phases and dword position within the cacheline
	always_comb
	begin
		rem_nxt = rem_r;
		pos_nxt = pos_r;
		if (in_idle && REQ_VALID)
		begin
			rem_nxt = req_len;
			pos_nxt = REQ.line_ofs;
		end
		else if (in_data)
		begin
			rem_nxt = rem_after;
			if (phase_done)
				pos_nxt = at_line_last ? 8'h00 : pos_r + 8'h01;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			state_r <= mtl_pkg::ST_IDLE;
			frame_n_r <= 1'b1;
			rem_r <= mtl_pkg::REM_RST;
			pos_r <= mtl_pkg::CNT_RST;
			cut_r <= 1'b0;
			first_r <= 1'b0;
			cmd_r <= mtl_pkg::CMD_RST;
			oe_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			frame_n_r <= frame_n_nxt;
			rem_r <= rem_nxt;
			pos_r <= pos_nxt;
			cut_r <= in_data & (cut_r | cut_now);
			first_r <= start_ok | (first_r & !phase_done);
			if (in_idle && REQ_VALID)
				cmd_r <= REQ.cmd;
			oe_r <= start_ok | in_addr | in_data;
		end
	end

	// outputs
	assign REQ_READY = in_idle;
	assign REQ_N = !in_arb;
	assign FRAME_N_O = frame_n_r;
	assign FRAME_N_OE = oe_r;
	assign IRDY_N_O = !irdy_act;
	assign IRDY_N_OE = oe_r;
	assign BUS_CMD = cmd_r;
	assign BUSY = !in_idle;
	assign STAT.lt_expired = lt_expired;
	assign STAT.cut_active = cut_r;
	assign STAT.irdy_forced = in_data & irdy_due & !USER_RDY;
	assign STAT.tgt_late = tgt_late;
	assign STAT.phase_done = phase_done;

endmodule // mtl_master_tenure

// ===== bench/mtl_asserts.sv
// port checker for the tenure sequencer
// bound to mtl_master_tenure; one clock, synchronous active-low reset
`timescale 1ns/10ps
module mtl_asserts
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [mtl_pkg::CNT_W-1:0] LAT_TIMER,
	input wire logic GNT_N,
	input wire logic FRAME_N_I,
	input wire logic FRAME_N_O,
	input wire logic FRAME_N_OE,
	input wire logic IRDY_N_I,
	input wire logic IRDY_N_O,
	input wire logic STOP_N,
	input wire mtl_pkg::mtl_stat_s STAT
);
	logic [8:0] fcnt_r;
	logic [8:0] fcnt_nxt;
	logic [8:0] lat9;
	// frame-low clocks of the current tenure, saturating
	assign fcnt_nxt = FRAME_N_O ? 9'h000 : (fcnt_r == 9'h1ff ? fcnt_r : fcnt_r + 9'h001);
	assign lat9 = {1'b0, LAT_TIMER};
	always_ff @(posedge CLK)
	begin
		fcnt_r <= RST_N ? fcnt_nxt : 9'h000;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_irdy_wait;
		(FRAME_N_OE && IRDY_N_O) [*8];
	endsequence
	a_start_idle_grant: assert property (!(!GNT_N && FRAME_N_I && IRDY_N_I) |=> !$fell(FRAME_N_O))
		else $error("frame started without grant on idle bus");
	a_irdy_limit: assert property (s_irdy_wait |=> !IRDY_N_O || !FRAME_N_OE)
		else $error("irdy later than eight clocks");
	a_stop_release: assert property (!STOP_N && !IRDY_N_O && !FRAME_N_O |=> FRAME_N_O)
		else $error("frame held after stop");
	a_cut_cause: assert property ($rose(STAT.cut_active) |-> $past(GNT_N) && $past(STAT.lt_expired))
		else $error("cut without expiry and grant loss");
	a_expiry_framed: assert property (STAT.lt_expired |-> !FRAME_N_O)
		else $error("expiry flagged with frame released");
	a_expiry_early: assert property (!FRAME_N_O && fcnt_r + 9'h001 < lat9 |-> !STAT.lt_expired)
		else $error("expiry before limit");
	a_expiry_late: assert property (!FRAME_N_O && fcnt_r > lat9 |-> STAT.lt_expired)
		else $error("no expiry after limit");
	a_expiry_holds: assert property ($fell(STAT.lt_expired) |-> FRAME_N_O)
		else $error("expiry dropped while framed");
	a_cut_floor: assert property ($rose(FRAME_N_O) && STAT.cut_active |-> fcnt_r >= lat9)
		else $error("cut tenure shorter than limit");
endmodule // mtl_asserts
bind mtl_master_tenure mtl_asserts chk_u
(
	.CLK, .RST_N, .LAT_TIMER, .GNT_N, .FRAME_N_I, .FRAME_N_O,
	.FRAME_N_OE, .IRDY_N_I, .IRDY_N_O, .STOP_N, .STAT
);

// ===== bench/mtl_partner.sv
// arbiter and target model facing the tenure sequencer
// frame_n and irdy_n are resolved bus levels; target lines are driven high while the bus is not active
`timescale 1ns/10ps
module mtl_partner
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic gnt_on,
	input wire logic stop_on,
	input wire logic [4:0] wait_n,
	output logic gnt_n,
	output logic trdy_n,
	output logic stop_n
);
	logic [4:0] wcnt_r;
	logic act;
	logic done;
	assign act = !frame_n || !irdy_n;
	assign done = !irdy_n && (!trdy_n || !stop_n);
	assign gnt_n = !gnt_on;
	// ready after wait_n clocks of each phase, the first counted from frame
	// values past the limits let the bench provoke the late-target report
	assign trdy_n = !(act && wcnt_r >= wait_n);
	// disconnect once the master is ready
	assign stop_n = !(act && stop_on && !irdy_n);
	always_ff @(posedge clk)
	begin
		wcnt_r <= (!rst_n || !act || done) ? 5'h00 : (wcnt_r == 5'h1f ? wcnt_r : wcnt_r + 5'h01);
	end
endmodule // mtl_partner

// ===== bench/test_mtl_master_tenure.sv
// self-checking bench for the tenure sequencer with arbiter and target model
// checker is bound from its own file; the other master is a bench-driven frame
`timescale 1ns/10ps
module test_mtl_master_tenure;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	mtl_pkg::mtl_req_s req = '0;
	mtl_pkg::mtl_stat_s stat;
	logic req_valid = 1'b0;
	logic user_rdy = 1'b1;
	logic [7:0] lat = 8'h10;
	logic gnt_on = 1'b0;
	logic stop_on = 1'b0;
	logic [4:0] wait_n = 5'h00;
	logic hbb = 1'b0;
	logic oth_f = 1'b0;
	logic [3:0] bus_cmd;
	logic cut_seen;
	logic forced_seen;
	wire req_ready, req_n, gnt_n, frame_o, frame_oe, irdy_o, irdy_oe, trdy_n, stop_n, busy;
	wire frame_i = frame_oe ? frame_o : !oth_f;
	wire irdy_i = irdy_oe ? irdy_o : !oth_f;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	int ph;
	int bus;
	int oth = 0;
	int late;
	always #5 CLK = !CLK;
	mtl_master_tenure dut_u
	(
		.CLK(CLK), .RST_N(RST_N), .REQ(req), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.USER_RDY(user_rdy), .LAT_TIMER(lat), .LINE_DWORDS(8'h08), .HBB_MODE(hbb), .REQ_N(req_n),
		.GNT_N(gnt_n), .FRAME_N_I(frame_i), .FRAME_N_O(frame_o), .FRAME_N_OE(frame_oe),
		.IRDY_N_I(irdy_i), .IRDY_N_O(irdy_o), .IRDY_N_OE(irdy_oe), .TRDY_N(trdy_n),
		.STOP_N(stop_n), .BUS_CMD(bus_cmd), .BUSY(busy), .STAT(stat)
	);
	mtl_partner far_u
	(
		.clk(CLK), .rst_n(RST_N), .frame_n(frame_i), .irdy_n(irdy_i), .gnt_on(gnt_on),
		.stop_on(stop_on), .wait_n(wait_n), .gnt_n(gnt_n), .trdy_n(trdy_n), .stop_n(stop_n)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one tenure; grant drops once frame is seen unless keep
	task automatic run(input logic [3:0] cmd, input logic [7:0] len, input logic [7:0] ofs,
		input logic [7:0] l, input logic keep);
		int g;
		logic drop;
		logic b;
		g = 0;
		drop = 1'b0;
		b = 1'b1;
		ph = 0;
		bus = 0;
		late = 0;
		cut_seen = 1'b0;
		forced_seen = 1'b0;
		@(posedge CLK);
		lat <= l;
		req <= {cmd, len, ofs};
		req_valid <= 1'b1;
		gnt_on <= 1'b1;
		@(posedge CLK);
		req_valid <= 1'b0;
		do
		begin
			@(negedge CLK);
			g++;
			b = busy;
			ph += stat.phase_done;
			late += stat.tgt_late;
			bus += !frame_i || !irdy_i;
			cut_seen |= stat.cut_active;
			forced_seen |= stat.irdy_forced;
			drop |= !keep && !frame_o;
			if (oth_f)
				chk(frame_oe, 1'b0);
			if (g == 1)
			begin
				chk(req_n, 1'b0);
				chk(irdy_oe, 1'b0);
				chk(bus_cmd, cmd);
			end
			@(posedge CLK);
			gnt_on <= !drop;
			oth_f <= g < oth;
		end
		while (b && g < 400);
		chk(g < 400, 1'b1);
	endtask
	task automatic t_grant_kept();
		run(4'h7, 8'h06, 8'h00, 8'h02, 1'b1);
		chk(ph, 6);
		chk(cut_seen, 1'b0);
	endtask
	task automatic t_cut_plain();
		@(posedge CLK);
		wait_n <= 5'h01;
		run(4'h7, 8'h1e, 8'h00, 8'h04, 1'b0);
		chk(ph < 30, 1'b1);
		chk(cut_seen, 1'b1);
		chk(bus >= 5 && bus <= 20, 1'b1);
		wait_n <= 5'h00;
	endtask
	// target overruns its limit: one late report per overrun phase
	task automatic t_slow_tgt();
		@(posedge CLK);
		wait_n <= 5'h0a;
		run(4'h7, 8'h02, 8'h00, 8'h40, 1'b1);
		chk(late, 1);
		chk(ph, 2);
		wait_n <= 5'h12;
		run(4'h7, 8'h01, 8'h00, 8'h40, 1'b1);
		chk(late, 1);
		@(posedge CLK);
		hbb <= 1'b1;
		run(4'h7, 8'h01, 8'h00, 8'h40, 1'b1);
		chk(late, 0);
		chk(ph, 1);
		hbb <= 1'b0;
		wait_n <= 5'h00;
	endtask
	task automatic t_cut_line();
		for (int o = 2; o < 6; o++)
		begin
			run(mtl_pkg::CMD_MWI, 8'h28, 8'(o), 8'h04, 1'b0);
			chk((ph + o) % 8, 0);
			chk(ph < 40 && cut_seen, 1'b1);
		end
	endtask
	task automatic t_stop();
		@(posedge CLK);
		stop_on <= 1'b1;
		run(4'h7, 8'h0a, 8'h00, 8'h40, 1'b1);
		// disconnect phase plus the closing phase with frame released
		chk(ph, 2);
		stop_on <= 1'b0;
	endtask
	task automatic t_slow_user();
		@(posedge CLK);
		user_rdy <= 1'b0;
		run(4'h6, 8'h02, 8'h00, 8'h40, 1'b1);
		chk(forced_seen, 1'b1);
		chk(ph, 2);
		user_rdy <= 1'b1;
	endtask
	task automatic t_busy_bus();
		@(posedge CLK);
		oth = 6;
		oth_f <= 1'b1;
		run(4'h7, 8'h03, 8'h00, 8'h40, 1'b1);
		chk(ph, 3);
		oth = 0;
	endtask
	initial
	begin
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		t_grant_kept();
		t_cut_plain();
		t_cut_line();
		t_stop();
		t_slow_user();
		t_busy_bus();
		t_slow_tgt();
		final_report();
	end
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end
endmodule // test_mtl_master_tenure
